// >>> design/tar_map.svh
`ifndef TAR_MAP_SVH
`define TAR_MAP_SVH

// register addresses, all on page 1
`define TAR_PAGE_CFG        1'b1
`define TAR_ADDR_DAC        6'h02
`define TAR_ADDR_REF        6'h03
`define TAR_ADDR_SWRST      6'h04
`define TAR_ADDR_CFG        6'h05

// field positions
`define TAR_DAC_SLEEP_BIT   15
`define TAR_REF_INT_BIT     4
`define TAR_REF_DLY_HI      3
`define TAR_REF_DLY_LO      2
`define TAR_REF_SLEEP_BIT   1
`define TAR_REF_LVL_BIT     0
`define TAR_CFG_FLAG_BIT    6
`define TAR_CFG_PRE_HI      5
`define TAR_CFG_PRE_LO      3
`define TAR_CFG_SNS_HI      2
`define TAR_CFG_SNS_LO      0

// reset values and codes
`define TAR_DAC_SLEEP_RST   1'b0
`define TAR_REF_INT_RST     1'b0
`define TAR_REF_DLY_RST     2'h0
`define TAR_REF_SLEEP_RST   1'b1
`define TAR_REF_LVL_RST     1'b0
`define TAR_CFG_PRE_RST     3'h0
`define TAR_CFG_SNS_RST     3'h0
`define TAR_SWRST_KEY       8'hbb
`define TAR_RD_UNMAPPED     16'hffff

// clock and times in ns
`define TAR_CLK_NS          25
`define TAR_SETTLE_100US_NS 100000
`define TAR_SETTLE_500US_NS 500000
`define TAR_SETTLE_1MS_NS   1000000
`define TAR_PRE0_NS         20000
`define TAR_PRE1_NS         84000
`define TAR_PRE2_NS         276000
`define TAR_PRE3_NS         340000
`define TAR_PRE4_NS         1044000
`define TAR_PRE5_NS         1108000
`define TAR_PRE6_NS         1300000
`define TAR_PRE7_NS         1364000
`define TAR_SNS0_NS         32000
`define TAR_SNS1_NS         96000
`define TAR_SNS2_NS         544000
`define TAR_SNS3_NS         608000
`define TAR_SNS4_NS         2080000
`define TAR_SNS5_NS         2144000
`define TAR_SNS6_NS         2592000
`define TAR_SNS7_NS         2656000

// least times round up to whole cycles
`define TAR_CYC(ns)         (((ns) + `TAR_CLK_NS - 1) / `TAR_CLK_NS)

`endif

// >>> design/tar_pkg.sv
package tar_pkg;

  // touch detect window sequencer
  typedef enum logic [1:0] {
    TAR_DET_IDLE = 2'b00,
    TAR_DET_PRE  = 2'b01,
    TAR_DET_SNS  = 2'b10
  } tar_det_e;

  typedef logic [15:0] tar_word_t;

endpackage

// >>> design/tar_cfg_regs.sv
`timescale 1ns/1ps
`include "tar_map.svh"
// Functional notes
// - bit 15 powers down the contrast converter
// - bit 4 selects on-chip reference, default external
// - hold off measurements by settle delay code
// - settle delay reads back as written
// - bit 1 sleeps reference between conversions
// - external selected keeps on-chip reference off
// - bit 0 picks 1.25V or 2.5V level
// - ready flag mirrors pin, low until read
// - precharge panel for selected time first
// - wait selected sense time between axes
// - averaging keeps busy until last conversion
module tar_cfg_regs
  import tar_pkg::*;
#(
  parameter int unsigned NREG   = 10,
  parameter int unsigned CNT_W  = 17,
  parameter int unsigned SET1_C = `TAR_CYC(`TAR_SETTLE_100US_NS),
  parameter int unsigned SET2_C = `TAR_CYC(`TAR_SETTLE_500US_NS),
  parameter int unsigned SET3_C = `TAR_CYC(`TAR_SETTLE_1MS_NS),
  parameter int unsigned PRE0_C = `TAR_CYC(`TAR_PRE0_NS),
  parameter int unsigned PRE1_C = `TAR_CYC(`TAR_PRE1_NS),
  parameter int unsigned PRE2_C = `TAR_CYC(`TAR_PRE2_NS),
  parameter int unsigned PRE3_C = `TAR_CYC(`TAR_PRE3_NS),
  parameter int unsigned PRE4_C = `TAR_CYC(`TAR_PRE4_NS),
  parameter int unsigned PRE5_C = `TAR_CYC(`TAR_PRE5_NS),
  parameter int unsigned PRE6_C = `TAR_CYC(`TAR_PRE6_NS),
  parameter int unsigned PRE7_C = `TAR_CYC(`TAR_PRE7_NS),
  parameter int unsigned SNS0_C = `TAR_CYC(`TAR_SNS0_NS),
  parameter int unsigned SNS1_C = `TAR_CYC(`TAR_SNS1_NS),
  parameter int unsigned SNS2_C = `TAR_CYC(`TAR_SNS2_NS),
  parameter int unsigned SNS3_C = `TAR_CYC(`TAR_SNS3_NS),
  parameter int unsigned SNS4_C = `TAR_CYC(`TAR_SNS4_NS),
  parameter int unsigned SNS5_C = `TAR_CYC(`TAR_SNS5_NS),
  parameter int unsigned SNS6_C = `TAR_CYC(`TAR_SNS6_NS),
  parameter int unsigned SNS7_C = `TAR_CYC(`TAR_SNS7_NS)
) (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic            reg_page_i,
  input  wire logic [5:0]      reg_addr_i,
  input  wire logic [15:0]     reg_wdata_i,
  output logic      [15:0]     reg_rdata_o,
  input  wire logic            conv_req_i,
  input  wire logic            conv_done_i,
  input  wire logic            conv_last_i,
  input  wire logic [NREG-1:0] conv_upd_i,
  input  wire logic [NREG-1:0] data_rd_i,
  input  wire logic            det_start_i,
  output logic                 dac_sleep_o,
  output logic                 ref_int_sel_o,
  output logic                 ref_power_o,
  output logic                 ref_level_o,
  output logic                 ref_ready_o,
  output logic                 result_ready_pin_n_o,
  output logic                 precharge_o,
  output logic                 sense_o,
  output logic                 det_done_o
);

  // longest window must fit the shared down counter
  initial begin
    if (NREG < 1 || SNS7_C >= (1 << CNT_W) || SET3_C >= (1 << CNT_W) ||
        PRE7_C >= (1 << CNT_W) || PRE0_C < 1 || SNS0_C < 1)
      $error("tar_cfg_regs: parameters out of range");
  end

  function automatic logic hit(input logic pg, input logic [5:0] ad,
                               input logic [5:0] tgt);
    hit = (pg == `TAR_PAGE_CFG) && (ad == tgt);
  endfunction

  function automatic logic [CNT_W-1:0] pre_cyc(input logic [2:0] c);
    unique case (c)
      3'h0: pre_cyc = CNT_W'(PRE0_C);
      3'h1: pre_cyc = CNT_W'(PRE1_C);
      3'h2: pre_cyc = CNT_W'(PRE2_C);
      3'h3: pre_cyc = CNT_W'(PRE3_C);
      3'h4: pre_cyc = CNT_W'(PRE4_C);
      3'h5: pre_cyc = CNT_W'(PRE5_C);
      3'h6: pre_cyc = CNT_W'(PRE6_C);
      3'h7: pre_cyc = CNT_W'(PRE7_C);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sns_cyc(input logic [2:0] c);
    unique case (c)
      3'h0: sns_cyc = CNT_W'(SNS0_C);
      3'h1: sns_cyc = CNT_W'(SNS1_C);
      3'h2: sns_cyc = CNT_W'(SNS2_C);
      3'h3: sns_cyc = CNT_W'(SNS3_C);
      3'h4: sns_cyc = CNT_W'(SNS4_C);
      3'h5: sns_cyc = CNT_W'(SNS5_C);
      3'h6: sns_cyc = CNT_W'(SNS6_C);
      3'h7: sns_cyc = CNT_W'(SNS7_C);
    endcase
  endfunction

  logic             wr_dac, wr_ref, wr_cfg, sw_rst;
  logic             dac_sleep_q;
  logic             ref_int_q, ref_sleep_q, ref_lvl_q;
  logic [1:0]       ref_dly_q;
  logic [2:0]       pre_code_q, sns_code_q;
  logic             ref_pwr_d, ref_pwr_q;
  logic [CNT_W-1:0] settle_q, settle_ld;
  logic [NREG-1:0]  pend_d, pend_q;
  logic             rdy_n_q;
  tar_word_t        rdata_q;
  tar_det_e         det_q;
  logic [CNT_W-1:0] det_cnt_q;
  logic [2:0]       win_pre_q, win_sns_q;
  logic             done_q;

  // write decode; the reset key lives in the upper byte only
  assign wr_dac = reg_wr_i && hit(reg_page_i, reg_addr_i, `TAR_ADDR_DAC);
  assign wr_ref = reg_wr_i && hit(reg_page_i, reg_addr_i, `TAR_ADDR_REF);
  assign wr_cfg = reg_wr_i && hit(reg_page_i, reg_addr_i, `TAR_ADDR_CFG);
  assign sw_rst = reg_wr_i && hit(reg_page_i, reg_addr_i, `TAR_ADDR_SWRST)
                  && (reg_wdata_i[15:8] == `TAR_SWRST_KEY);

  // converter power-down control
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_sleep_q <= `TAR_DAC_SLEEP_RST;
    end else if (sw_rst) begin
      dac_sleep_q <= `TAR_DAC_SLEEP_RST;
    end else if (wr_dac) begin
      dac_sleep_q <= reg_wdata_i[`TAR_DAC_SLEEP_BIT];
    end
  end

  // reference control fields, unused bits never stored
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_int_q   <= `TAR_REF_INT_RST;
      ref_dly_q   <= `TAR_REF_DLY_RST;
      ref_sleep_q <= `TAR_REF_SLEEP_RST;
      ref_lvl_q   <= `TAR_REF_LVL_RST;
    end else if (sw_rst) begin
      ref_int_q   <= `TAR_REF_INT_RST;
      ref_dly_q   <= `TAR_REF_DLY_RST;
      ref_sleep_q <= `TAR_REF_SLEEP_RST;
      ref_lvl_q   <= `TAR_REF_LVL_RST;
    end else if (wr_ref) begin
      ref_int_q   <= reg_wdata_i[`TAR_REF_INT_BIT];
      ref_dly_q   <= reg_wdata_i[`TAR_REF_DLY_HI:`TAR_REF_DLY_LO];
      ref_sleep_q <= reg_wdata_i[`TAR_REF_SLEEP_BIT];
      ref_lvl_q   <= reg_wdata_i[`TAR_REF_LVL_BIT];
    end
  end

  // touch detect timing codes; the flag bit is read-only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_code_q <= `TAR_CFG_PRE_RST;
      sns_code_q <= `TAR_CFG_SNS_RST;
    end else if (sw_rst) begin
      pre_code_q <= `TAR_CFG_PRE_RST;
      sns_code_q <= `TAR_CFG_SNS_RST;
    end else if (wr_cfg) begin
      pre_code_q <= reg_wdata_i[`TAR_CFG_PRE_HI:`TAR_CFG_PRE_LO];
      sns_code_q <= reg_wdata_i[`TAR_CFG_SNS_HI:`TAR_CFG_SNS_LO];
    end
  end

  // on-chip reference power: off when external, else always or per conv
  assign ref_pwr_d = ref_int_q && (!ref_sleep_q || conv_req_i);

  always_comb begin
    unique case (ref_dly_q)
      2'h0: settle_ld = '0;
      2'h1: settle_ld = CNT_W'(SET1_C);
      2'h2: settle_ld = CNT_W'(SET2_C);
      2'h3: settle_ld = CNT_W'(SET3_C);
    endcase
  end

  // settle counter restarts on every power-up of the reference
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_pwr_q <= 1'b0;
      settle_q  <= '0;
    end else begin
      ref_pwr_q <= ref_pwr_d;
      if (ref_pwr_d && !ref_pwr_q) begin
        settle_q <= settle_ld;
      end else if (!ref_pwr_d) begin
        settle_q <= '0;
      end else if (settle_q != '0) begin
        settle_q <= settle_q - 1'b1;
      end
    end
  end

  // pending data registers; a new conversion wins over a same-cycle read
  assign pend_d = ((pend_q & ~data_rd_i) |
                   ((conv_done_i && conv_last_i) ? conv_upd_i : '0));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q  <= '0;
      rdy_n_q <= 1'b1;
    end else if (sw_rst) begin
      pend_q  <= '0;
      rdy_n_q <= 1'b1;
    end else begin
      pend_q  <= pend_d;
      rdy_n_q <= ~|pend_d;
    end
  end

  // touch detect sequencer: precharge window then sense window
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      det_q     <= TAR_DET_IDLE;
      det_cnt_q <= '0;
      win_pre_q <= '0;
      win_sns_q <= '0;
      done_q    <= 1'b0;
    end else if (sw_rst) begin
      det_q     <= TAR_DET_IDLE;
      det_cnt_q <= '0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (det_q)
        TAR_DET_IDLE: begin
          if (det_start_i) begin
            // codes latched so a mid-window write cannot stretch it
            win_pre_q <= pre_code_q;
            win_sns_q <= sns_code_q;
            det_cnt_q <= pre_cyc(pre_code_q) - 1'b1;
            det_q     <= TAR_DET_PRE;
          end
        end
        TAR_DET_PRE: begin
          if (det_cnt_q == '0) begin
            det_cnt_q <= sns_cyc(win_sns_q) - 1'b1;
            det_q     <= TAR_DET_SNS;
          end else begin
            det_cnt_q <= det_cnt_q - 1'b1;
          end
        end
        TAR_DET_SNS: begin
          if (det_cnt_q == '0) begin
            done_q <= 1'b1;
            det_q  <= TAR_DET_IDLE;
          end else begin
            det_cnt_q <= det_cnt_q - 1'b1;
          end
        end
        default: det_q <= TAR_DET_IDLE;
      endcase
    end
  end

  // read data captured on the edge that takes the strobe; reserved reads all ones
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      rdata_q <= `TAR_RD_UNMAPPED;
      if (hit(reg_page_i, reg_addr_i, `TAR_ADDR_DAC)) begin
        rdata_q <= {dac_sleep_q, 15'h0000};
      end else if (hit(reg_page_i, reg_addr_i, `TAR_ADDR_REF)) begin
        rdata_q <= {11'h000, ref_int_q, ref_dly_q, ref_sleep_q,
                    ref_lvl_q};
      end else if (hit(reg_page_i, reg_addr_i, `TAR_ADDR_CFG)) begin
        rdata_q <= {9'h000, rdy_n_q, pre_code_q, sns_code_q};
      end
    end
  end

  assign reg_rdata_o          = rdata_q;
  assign dac_sleep_o          = dac_sleep_q;
  assign ref_int_sel_o        = ref_int_q;
  assign ref_power_o          = ref_pwr_q;
  assign ref_level_o          = ref_lvl_q;
  assign ref_ready_o          = ref_pwr_q && (settle_q == '0);
  assign result_ready_pin_n_o = rdy_n_q;
  assign precharge_o          = (det_q == TAR_DET_PRE);
  assign sense_o              = (det_q == TAR_DET_SNS);
  assign det_done_o           = done_q;

  // helper: length of the current window, for the checks below
  logic [CNT_W-1:0] run_q;
  logic [2:0]       run_pre_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= '0;
    end else if (det_q != TAR_DET_IDLE && det_cnt_q != '0) begin
      run_q <= run_q + 1'b1;
    end else begin
      run_q <= '0;
    end
  end
  assign run_pre_q = win_pre_q;

  // helper: cycles since the reference last powered up, and the hold-off
  // chosen at that moment, so any settle length can be checked
  logic [CNT_W-1:0] pwr_age_q, pwr_need_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_age_q  <= '0;
      pwr_need_q <= '0;
    end else if (ref_pwr_d && !ref_pwr_q) begin
      pwr_age_q  <= '0;
      pwr_need_q <= settle_ld;
    end else if (ref_pwr_d && pwr_age_q != '1) begin
      pwr_age_q  <= pwr_age_q + 1'b1;
    end
  end

  property p_dac_sleep;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_dac && !sw_rst |=> dac_sleep_o == $past(reg_wdata_i[15]);
  endproperty
  a_dac_sleep: assert property (p_dac_sleep)
    else $error("converter sleep bit not taken from write");

  property p_ext_ref_off;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !ref_int_q |=> !ref_power_o;
  endproperty
  a_ext_ref_off: assert property (p_ext_ref_off)
    else $error("on-chip reference powered while external selected");

  property p_ref_always;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      ref_int_q && !ref_sleep_q |=> ref_power_o;
  endproperty
  a_ref_always: assert property (p_ref_always)
    else $error("reference not powered with sleep cleared");

  property p_settle_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      ref_ready_o |-> pwr_age_q >= pwr_need_q;
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("reference ready before settle delay");

  property p_ref_readback;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i && hit(reg_page_i, reg_addr_i, `TAR_ADDR_REF)
      |=> reg_rdata_o[3:2] == $past(ref_dly_q) &&
          reg_rdata_o[4] == $past(ref_int_q);
  endproperty
  a_ref_readback: assert property (p_ref_readback)
    else $error("reference register readback mismatch");

  property p_unused_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i && hit(reg_page_i, reg_addr_i, `TAR_ADDR_CFG)
      |=> reg_rdata_o[15:7] == 9'h000 &&
          reg_rdata_o[6] == $past(result_ready_pin_n_o);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("config readback wrong in unused bits or flag");

  property p_flag_low;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      conv_done_i && conv_last_i && |conv_upd_i && !sw_rst
      |=> !result_ready_pin_n_o;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("result ready did not go low on conversion");

  property p_avg_busy;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      conv_done_i && !conv_last_i && pend_q == '0 |=> result_ready_pin_n_o;
  endproperty
  a_avg_busy: assert property (p_avg_busy)
    else $error("result ready low before last averaged conversion");

  property p_pre_len;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      precharge_o && det_cnt_q == '0 && !sw_rst
      |-> run_q == pre_cyc(run_pre_q) - 1'b1 ##1 sense_o;
  endproperty
  a_pre_len: assert property (p_pre_len)
    else $error("precharge window length wrong");

  property p_sns_len;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      sense_o && det_cnt_q == '0 && !sw_rst
      |-> run_q == sns_cyc(win_sns_q) - 1'b1 ##1 det_done_o;
  endproperty
  a_sns_len: assert property (p_sns_len)
    else $error("sense window length wrong");

  property p_soft_reset;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      sw_rst |=> ref_sleep_q && !ref_int_q && !dac_sleep_o &&
                 result_ready_pin_n_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset did not restore defaults");

endmodule

// >>> verif/tar_host.sv
`timescale 1ns/1ps
// converter end and host data reads, driven from negedges by the bench
module tar_host #(
  parameter int unsigned NREG = 10
) (
  input  wire logic            sys_clk_i,
  output logic                 conv_req_o,
  output logic                 conv_done_o,
  output logic                 conv_last_o,
  output logic      [NREG-1:0] conv_upd_o,
  output logic      [NREG-1:0] data_rd_o
);
  // idle at time zero: no conversion, no read
  initial begin
    conv_req_o  = 1'b0;
    conv_done_o = 1'b0;
    conv_last_o = 1'b0;
    conv_upd_o  = '0;
    data_rd_o   = '0;
  end

  // converter wants the reference while this level is high
  task automatic set_req(input logic v);
    @(negedge sys_clk_i);
    conv_req_o <= v;
  endtask

  // one cycle of conversion end and host reads; qualifiers then scrambled
  task automatic xfer(input logic [NREG-1:0] upd, input logic last,
                      input logic [NREG-1:0] rd);
    @(negedge sys_clk_i);
    conv_done_o <= |upd;
    conv_last_o <= last;
    conv_upd_o  <= upd;
    data_rd_o   <= rd;
    @(negedge sys_clk_i);
    conv_done_o <= 1'b0;
    conv_last_o <= ~last;
    conv_upd_o  <= ~upd; // stale qualifiers must not matter
    data_rd_o   <= '0;
  endtask

  // host reads updated data registers one by one, gap sets how slowly
  task automatic read_regs(input logic [NREG-1:0] mask, input int gap);
    for (int k = 0; k < NREG; k++) begin
      if (mask[k]) begin
        xfer('0, 1'b0, NREG'(1) << k);
        repeat (gap) @(negedge sys_clk_i);
      end
    end
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb
  import tar_pkg::*;
;
  localparam int unsigned SET_C[4] = '{0, 5, 7, 9};
  localparam int unsigned PRE_C[8] = '{3, 4, 5, 6, 7, 8, 9, 10};
  localparam int unsigned SNS_C[8] = '{4, 5, 6, 7, 8, 9, 10, 11};
  logic            sys_clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic            reg_wr_i = 1'b0;
  logic            reg_rd_i = 1'b0;
  logic            reg_page_i = 1'b1;
  logic [5:0]      reg_addr_i = 6'h00;
  tar_word_t       reg_wdata_i = 16'h0000;
  logic            det_start_i = 1'b0;
  tar_word_t       reg_rdata_o;
  logic            conv_req_i, conv_done_i, conv_last_i;
  logic [9:0]      conv_upd_i, data_rd_i;
  logic            dac_sleep_o, ref_int_sel_o, ref_power_o, ref_level_o;
  logic            ref_ready_o, result_ready_pin_n_o;
  logic            precharge_o, sense_o, det_done_o;
  int              fails = 0;
  int              check_count = 0;
  int              cycles = 0;

  // 40 MHz
  always #12.5 sys_clk_i = ~sys_clk_i;

  // counts shortened so every window fits a short run
  tar_cfg_regs #(
    .SET1_C(5), .SET2_C(7), .SET3_C(9),
    .PRE0_C(3), .PRE1_C(4), .PRE2_C(5), .PRE3_C(6),
    .PRE4_C(7), .PRE5_C(8), .PRE6_C(9), .PRE7_C(10),
    .SNS0_C(4), .SNS1_C(5), .SNS2_C(6), .SNS3_C(7),
    .SNS4_C(8), .SNS5_C(9), .SNS6_C(10), .SNS7_C(11)
  ) tar_cfg_regs_i (
    .sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_page_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .conv_req_i, .conv_done_i, .conv_last_i,
    .conv_upd_i, .data_rd_i, .det_start_i, .dac_sleep_o, .ref_int_sel_o,
    .ref_power_o, .ref_level_o, .ref_ready_o, .result_ready_pin_n_o,
    .precharge_o, .sense_o, .det_done_o
  );

  tar_host #(.NREG(10)) tar_host_i (
    .sys_clk_i   (sys_clk_i),
    .conv_req_o  (conv_req_i),
    .conv_done_o (conv_done_i),
    .conv_last_o (conv_last_i),
    .conv_upd_o  (conv_upd_i),
    .data_rd_o   (data_rd_i)
  );

  task automatic complete_run();
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      $display("MISMATCH %0t timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input tar_word_t got, input tar_word_t exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // one write strobe; data scrambled after so a late sample shows up
  task automatic wr(input logic [5:0] a, input tar_word_t d);
    @(negedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(negedge sys_clk_i);
    reg_wr_i    <= 1'b0;
    reg_wdata_i <= ~d;
  endtask

  // read data stands from the edge that takes the strobe
  task automatic rchk(input logic p, input logic [5:0] a,
                      input tar_word_t e, input string m);
    @(negedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_page_i <= p;
    reg_addr_i <= a;
    @(negedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    reg_page_i <= 1'b1;
    chk(reg_rdata_o, e, m);
  endtask

  task automatic t_defaults();
    rchk(1'b1, 6'h02, 16'h0000, "dac default");
    rchk(1'b1, 6'h03, 16'h0002, "ref default");
    rchk(1'b1, 6'h05, 16'h0040, "cfg default");
    rchk(1'b1, 6'h04, 16'hffff, "reset reg read");
    rchk(1'b1, 6'h07, 16'hffff, "unmapped read");
    rchk(1'b0, 6'h03, 16'hffff, "other page read");
    chk(result_ready_pin_n_o, 1'b1, "pin default");
  endtask

  task automatic t_fields();
    wr(6'h02, 16'hffff);
    chk(dac_sleep_o, 1'b1, "dac sleep set");
    rchk(1'b1, 6'h02, 16'h8000, "dac unused bits");
    wr(6'h02, 16'h7fff);
    chk(dac_sleep_o, 1'b0, "dac sleep clear");
    wr(6'h03, 16'hffe0);
    rchk(1'b1, 6'h03, 16'h0000, "ref unused bits");
    for (int k = 0; k < 4; k++) begin
      wr(6'h03, tar_word_t'(k << 2) | 16'h0001);
      rchk(1'b1, 6'h03, tar_word_t'(k << 2) | 16'h0001, "delay rb");
      chk(ref_level_o, 1'b1, "ref level high");
    end
    wr(6'h05, 16'hffff);
    rchk(1'b1, 6'h05, 16'h007f, "cfg write");
    wr(6'h05, 16'h0000);
    rchk(1'b1, 6'h05, 16'h0040, "flag not writable");
  endtask

  task automatic t_ref();
    int n;
    for (int k = 0; k < 4; k++) begin
      wr(6'h03, 16'h0000);
      wait_n(3);
      chk(ref_power_o, 1'b0, "ext keeps on-chip off");
      chk(ref_level_o, 1'b0, "ref level low");
      wr(6'h03, 16'h0010 | tar_word_t'(k << 2));
      chk(ref_int_sel_o, 1'b1, "on-chip selected");
      n = 0;
      while (ref_power_o !== 1'b1 && n < 5) begin
        @(negedge sys_clk_i);
        n++;
      end
      chk(ref_power_o, 1'b1, "always powered");
      n = 0;
      while (ref_ready_o !== 1'b1 && n < 20) begin
        @(negedge sys_clk_i);
        n++;
      end
      // one cycle of slack for where the count starts
      chk(tar_word_t'(n >= SET_C[k] && n <= SET_C[k] + 1), 1, "settle");
    end
    wr(6'h03, 16'h0012);
    wait_n(3);
    chk(ref_power_o, 1'b0, "asleep between conv");
    tar_host_i.set_req(1'b1);
    wait_n(3);
    chk(ref_power_o, 1'b1, "powered in conv");
    tar_host_i.set_req(1'b0);
    wait_n(3);
    chk(ref_power_o, 1'b0, "off after conv");
    wr(6'h03, 16'h0002);
    tar_host_i.set_req(1'b1);
    wait_n(3);
    chk(ref_power_o, 1'b0, "ext ignores conv");
    tar_host_i.set_req(1'b0);
  endtask

  task automatic t_ready();
    tar_host_i.xfer(10'h003, 1'b1, 10'h000);
    wait_n(1);
    chk(result_ready_pin_n_o, 1'b0, "pin low");
    rchk(1'b1, 6'h05, 16'h0000, "flag mirrors pin");
    tar_host_i.read_regs(10'h001, 2);
    wait_n(2);
    chk(result_ready_pin_n_o, 1'b0, "partial read");
    tar_host_i.read_regs(10'h002, 0);
    wait_n(2);
    chk(result_ready_pin_n_o, 1'b1, "all read");
    rchk(1'b1, 6'h05, 16'h0040, "flag high");
    repeat (3) tar_host_i.xfer(10'h004, 1'b0, 10'h000);
    wait_n(2);
    chk(result_ready_pin_n_o, 1'b1, "average busy");
    tar_host_i.xfer(10'h004, 1'b1, 10'h000);
    wait_n(2);
    chk(result_ready_pin_n_o, 1'b0, "average done");
    tar_host_i.xfer(10'h004, 1'b1, 10'h004);
    wait_n(2);
    chk(result_ready_pin_n_o, 1'b0, "new result wins");
    tar_host_i.read_regs(10'h004, 1);
    wait_n(2);
    chk(result_ready_pin_n_o, 1'b1, "read clears");
  endtask

  // second start while busy must be ignored
  task automatic t_det();
    int np, ns, nd, n;
    for (int k = 0; k < 8; k++) begin
      wr(6'h05, tar_word_t'(k << 3) | tar_word_t'(7 - k));
      @(negedge sys_clk_i);
      det_start_i <= 1'b1;
      np = 0;
      ns = 0;
      nd = 0;
      n = 0;
      while (nd == 0 && n < 60) begin
        @(negedge sys_clk_i);
        det_start_i <= (n == 2);
        np += int'(precharge_o === 1'b1);
        ns += int'(sense_o === 1'b1);
        nd += int'(det_done_o === 1'b1);
        n++;
      end
      chk(tar_word_t'(np), tar_word_t'(PRE_C[k]), "precharge");
      chk(tar_word_t'(ns), tar_word_t'(SNS_C[7 - k]), "sense");
      @(negedge sys_clk_i);
      chk(det_done_o, 1'b0, "done one cycle");
    end
  endtask

  task automatic t_swrst();
    wr(6'h03, 16'h001d);
    wr(6'h02, 16'h8000);
    wr(6'h05, 16'h003f);
    tar_host_i.xfer(10'h001, 1'b1, 10'h000);
    rchk(1'b1, 6'h05, 16'h003f, "pending flag");
    wr(6'h04, 16'haa00);
    rchk(1'b1, 6'h03, 16'h001d, "bad key");
    wr(6'h04, 16'hbb00);
    rchk(1'b1, 6'h03, 16'h0002, "ref restored");
    rchk(1'b1, 6'h02, 16'h0000, "dac restored");
    rchk(1'b1, 6'h05, 16'h0040, "cfg restored");
    chk(result_ready_pin_n_o, 1'b1, "pending cleared");
  endtask

  // reset for ten cycles, then each scenario in turn
  initial begin
    wait_n(10);
    rst_n_i <= 1'b1;
    t_defaults();
    t_fields();
    t_ref();
    t_ready();
    t_det();
    t_swrst();
    complete_run();
  end
endmodule
